// ---- hw/hfe_flag_bank.sv ----
`timescale 1ns/1ps
module hfe_flag_bank #(
  parameter int N = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // Set and clear
  input wire logic [N-1:0] set_i,
  input wire logic clr_i,
  // Flags
  output logic [N-1:0] flag_o
);
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_flag
      logic next_flag;
      // Sticky bit, set beats a same-cycle clear
      always_comb begin
        next_flag = set_i[g] | (flag_o[g] & ~clr_i);
      end
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          flag_o[g] <= 1'b0;
        end else begin
          flag_o[g] <= next_flag;
        end
      end
      a_set_kept: assert property (@(posedge clock_i) disable iff (!nrst_i)
        set_i[g] |=> flag_o[g]) else $error("flag lost its set");
      a_flag_sticky: assert property (@(posedge clock_i) disable iff (!nrst_i)
        flag_o[g] && !clr_i |=> flag_o[g]) else $error("flag dropped without a read");
    end
  endgenerate
endmodule

// ---- hw/hfe_status_events.sv ----
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module hfe_status_events #(
  parameter int MF_CYCLES = hfe_pkg::MF_CYCLES,
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // AXI4-Lite write
  input wire logic [hfe_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [hfe_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Pattern monitor
  input wire logic prbs_sync_i,
  output logic pattern_detect_status_o,
  // Receive path
  input wire logic rx_byte_valid_i,
  input wire logic rx_fifo_full_i,
  input wire logic rx_frame_end_i,
  output logic rx_store_o,
  output logic frame_status_overflow_o,
  // Transmit path
  input wire logic tx_frame_active_i,
  input wire logic tx_byte_req_i,
  input wire logic tx_fifo_empty_i,
  input wire logic tx_message_end_cmd_i,
  input wire logic tx_last_bit_i,
  output logic tx_abort_o,
  output logic tx_disable_o,
  output logic [hfe_pkg::XS_NUM*hfe_pkg::XS_W-1:0] tx_sig_shift_o,
  // Signaling unit monitor
  input wire logic [CNT_W-1:0] su_err_count_i,
  input wire logic su_invalid_frame_i,
  input wire logic su_valid_frame_i,
  // Interrupt line
  output logic irq_o
);
  localparam int MF_W = $clog2(MF_CYCLES);
  localparam int SHW = hfe_pkg::XS_NUM * hfe_pkg::XS_W;

  logic [7:0] mask, ctrl, thr, isr, set_vec, ev;
  logic [7:0] next_mask, next_ctrl, next_thr;
  logic [hfe_pkg::XS_W-1:0] xs [hfe_pkg::XS_NUM];
  logic [hfe_pkg::XS_W-1:0] next_xs [hfe_pkg::XS_NUM];
  logic [SHW-1:0] xs_flat, next_shift;
  logic [MF_W-1:0] mf_cnt, next_mf_cnt;
  logic mf_tick, prbs_q, lock, next_lock, fso, next_fso, abort, next_abort;
  logic over_q, next_over_q, rep, next_rep, over;
  logic pat_ev, ovf_ev, all_sent_flag_ev, udr_ev, su_error_threshold_flag_ev, gsum;
  logic wr_en, rd_en, isr_rd, bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  logic vis, pms, hdlc, ss7;

  assign vis = ctrl[hfe_pkg::CT_VIS];
  assign pms = ctrl[hfe_pkg::CT_PMS];
  assign hdlc = ctrl[hfe_pkg::CT_HDLC];
  assign ss7 = ctrl[hfe_pkg::CT_SS7];

  // Bus handshakes; one write and one read in flight
  assign wr_en = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid;
  assign rd_en = s_axi_arvalid_i & ~rvalid;
  assign isr_rd = rd_en & (s_axi_araddr_i == hfe_pkg::ISR_OFS);
  assign s_axi_awready_o = wr_en;
  assign s_axi_wready_o = wr_en;
  assign s_axi_arready_o = rd_en;
  assign s_axi_bvalid_o = bvalid;
  assign s_axi_bresp_o = bresp;
  assign s_axi_rvalid_o = rvalid;
  assign s_axi_rresp_o = rresp;
  assign s_axi_rdata_o = rdata;

  // Event detection from line timing inputs
  always_comb begin
    pat_ev = pms & (prbs_sync_i ^ prbs_q);
    ovf_ev = rx_byte_valid_i & rx_fifo_full_i;
    all_sent_flag_ev = hdlc & tx_last_bit_i & tx_fifo_empty_i;
    udr_ev = tx_frame_active_i & tx_byte_req_i & tx_fifo_empty_i
             & ~tx_message_end_cmd_i & ~lock;
    over = su_err_count_i > thr[CNT_W-1:0];
    // Repeat while an invalid frame keeps the count high
    su_error_threshold_flag_ev = ss7 & ((over & ~over_q) | (rep & mf_tick));
    ev = 8'h00;
    ev[hfe_pkg::FL_PAT] = pat_ev;
    ev[hfe_pkg::FL_RDO] = ovf_ev;
    ev[hfe_pkg::FL_ALL_SENT_FLAG] = all_sent_flag_ev;
    ev[hfe_pkg::FL_UDR] = udr_ev;
    ev[hfe_pkg::FL_XMB] = mf_tick;
    ev[hfe_pkg::FL_SU_ERROR_THRESHOLD_FLAG] = su_error_threshold_flag_ev;
    // Masked events only land when show-masked is on
    set_vec = ev & (~mask | {8{vis}});
  end

  hfe_flag_bank #(
    .N(8)
  ) u_flags (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .set_i(set_vec),
    .clr_i(isr_rd),
    .flag_o(isr)
  );

  // Masked flags never reach the line or the summary
  assign gsum = |(isr & ~mask);
  assign irq_o = gsum;
  // Overflowed bytes are dropped, reception goes on
  assign rx_store_o = rx_byte_valid_i & ~rx_fifo_full_i;
  assign tx_abort_o = abort;
  assign tx_disable_o = lock;
  assign pattern_detect_status_o = prbs_q;
  assign frame_status_overflow_o = fso;

  // Multiframe divider and line-side state
  always_comb begin
    mf_tick = (mf_cnt == MF_W'(MF_CYCLES - 1));
    next_mf_cnt = mf_tick ? '0 : mf_cnt + 1'b1;
    // Lock-out held until the ISR read; no new underrun is detected while it is held
    next_lock = udr_ev | (lock & ~isr_rd);
    next_abort = udr_ev;
    next_fso = ovf_ev | (fso & ~rx_frame_end_i);
    next_over_q = over;
    next_rep = ss7 & over & (su_invalid_frame_i | (rep & ~su_valid_frame_i));
    // Registers stay loaded so stale content is resent
    next_shift = mf_tick ? xs_flat : tx_sig_shift_o;
  end

  genvar i;
  generate
    for (i = 0; i < hfe_pkg::XS_NUM; i++) begin : g_xs
      assign xs_flat[i*hfe_pkg::XS_W +: hfe_pkg::XS_W] = xs[i];
    end
  endgenerate

  // Register writes and read answers
  always_comb begin
    next_mask = mask;
    next_ctrl = ctrl;
    next_thr = thr;
    next_xs = xs;
    next_bvalid = bvalid & ~s_axi_bready_i;
    next_bresp = bresp;
    next_rvalid = rvalid & ~s_axi_rready_i;
    next_rresp = rresp;
    next_rdata = rdata;
    if (wr_en) begin
      next_bvalid = 1'b1;
      next_bresp = hfe_pkg::RESP_OK;
      if (s_axi_awaddr_i[7:6] == hfe_pkg::XS_BASE[7:6] && s_axi_awaddr_i[1:0] == 2'h0) begin
        if (s_axi_wstrb_i[0]) begin
          next_xs[s_axi_awaddr_i[5:2]] = s_axi_wdata_i[7:0];
        end
      end else if (s_axi_awaddr_i == hfe_pkg::MASK_OFS) begin
        if (s_axi_wstrb_i[0]) begin
          next_mask = s_axi_wdata_i[7:0];
        end
      end else if (s_axi_awaddr_i == hfe_pkg::CTRL_OFS) begin
        if (s_axi_wstrb_i[0]) begin
          next_ctrl = {4'h0, s_axi_wdata_i[3:0]};
        end
      end else if (s_axi_awaddr_i == hfe_pkg::THR_OFS) begin
        if (s_axi_wstrb_i[0]) begin
          next_thr = s_axi_wdata_i[7:0];
        end
      end else if (s_axi_awaddr_i != hfe_pkg::ISR_OFS && s_axi_awaddr_i != hfe_pkg::STAT_OFS) begin
        next_bresp = hfe_pkg::RESP_ERR;
      end
    end
    if (rd_en) begin
      next_rvalid = 1'b1;
      next_rresp = hfe_pkg::RESP_OK;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr_i[7:6] == hfe_pkg::XS_BASE[7:6] && s_axi_araddr_i[1:0] == 2'h0) begin
        next_rdata[7:0] = xs[s_axi_araddr_i[5:2]];
      end else begin
        unique case (s_axi_araddr_i)
          hfe_pkg::ISR_OFS: next_rdata[7:0] = isr;
          hfe_pkg::MASK_OFS: next_rdata[7:0] = mask;
          hfe_pkg::CTRL_OFS: next_rdata[7:0] = ctrl;
          hfe_pkg::THR_OFS: next_rdata[7:0] = thr;
          hfe_pkg::STAT_OFS: next_rdata[2:0] = {gsum, lock, prbs_q};
          default: next_rresp = hfe_pkg::RESP_ERR;
        endcase
      end
    end
  end

  // Register all state
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      mask <= hfe_pkg::MASK_RST;
      ctrl <= hfe_pkg::CTRL_RST;
      thr <= hfe_pkg::THR_RST;
      xs <= '{default: hfe_pkg::XS_RST};
      tx_sig_shift_o <= {hfe_pkg::XS_NUM{hfe_pkg::XS_RST}};
      mf_cnt <= '0;
      prbs_q <= 1'b0;
      lock <= 1'b0;
      abort <= 1'b0;
      fso <= 1'b0;
      over_q <= 1'b0;
      rep <= 1'b0;
      bvalid <= 1'b0;
      bresp <= hfe_pkg::RESP_OK;
      rvalid <= 1'b0;
      rresp <= hfe_pkg::RESP_OK;
      rdata <= 32'h0000_0000;
    end else begin
      mask <= next_mask;
      ctrl <= next_ctrl;
      thr <= next_thr;
      xs <= next_xs;
      tx_sig_shift_o <= next_shift;
      mf_cnt <= next_mf_cnt;
      prbs_q <= prbs_sync_i;
      lock <= next_lock;
      abort <= next_abort;
      fso <= next_fso;
      over_q <= next_over_q;
      rep <= next_rep;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence s_underrun;
    udr_ev ##1 (tx_abort_o && tx_disable_o);
  endsequence
  sequence s_mf_copy;
    mf_tick ##1 (tx_sig_shift_o == $past(xs_flat));
  endsequence

  a_pat_flag: assert property (pms && (prbs_sync_i != pattern_detect_status_o)
    && (vis || !mask[hfe_pkg::FL_PAT]) |=> isr[hfe_pkg::FL_PAT]) else $error("pattern change lost");
  a_ovf_drop: assert property (rx_fifo_full_i |-> !rx_store_o) else $error("byte stored into full fifo");
  a_ovf_flag: assert property (ovf_ev |=> frame_status_overflow_o
    && (isr[hfe_pkg::FL_RDO] || (mask[hfe_pkg::FL_RDO] && !vis))) else $error("overflow not flagged");
  a_all_sent_flag_mode: assert property (!hdlc |-> !all_sent_flag_ev) else $error("all-sent outside hdlc mode");
  a_udr_abort: assert property (udr_ev |-> s_underrun) else $error("underrun without abort");
  a_lock_hold: assert property (tx_disable_o && !isr_rd |=> tx_disable_o) else $error("lock-out released early");
  a_lock_free: assert property (tx_disable_o && isr_rd |=> !tx_disable_o) else $error("lock-out not released");
  a_mf_copy: assert property (mf_tick |-> s_mf_copy) else $error("signaling copy missed");
  a_mf_period: assert property (mf_tick |=> !mf_tick [*2]) else $error("multiframe ticks too close");
  a_su_error_threshold_flag_mode: assert property (!ss7 |-> !su_error_threshold_flag_ev) else $error("threshold event outside ss7");
  a_su_error_threshold_flag_below: assert property (!over |-> !(su_error_threshold_flag_ev && !rep)) else $error("threshold event below limit");
  a_su_error_threshold_flag_flag: assert property (ss7 && over && !over_q && (vis || !mask[hfe_pkg::FL_SU_ERROR_THRESHOLD_FLAG])
    |=> isr[hfe_pkg::FL_SU_ERROR_THRESHOLD_FLAG]) else $error("threshold flag not raised");
  a_read_clear: assert property (isr_rd && set_vec == 8'h00 |=> isr == 8'h00) else $error("read did not clear");
  a_masked_irq: assert property (irq_o == |(isr & ~mask)) else $error("masked flag drives interrupt");
endmodule

// ---- include/hfe_pkg.sv ----
package hfe_pkg;
  // Register window and offsets (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] ISR_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h04;
  localparam logic [7:0] CTRL_OFS = 8'h08;
  localparam logic [7:0] THR_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10;
  localparam logic [7:0] XS_BASE = 8'h40;
  localparam int XS_NUM = 16;
  localparam int XS_W = 8;
  // Status flag positions
  localparam int FL_PAT = 7;
  localparam int FL_RDO = 6;
  localparam int FL_ALL_SENT_FLAG = 5;
  localparam int FL_UDR = 4;
  localparam int FL_XMB = 3;
  localparam int FL_SU_ERROR_THRESHOLD_FLAG = 2;
  // Control bit positions
  localparam int CT_VIS = 0;
  localparam int CT_PMS = 1;
  localparam int CT_HDLC = 2;
  localparam int CT_SS7 = 3;
  // Status bit positions
  localparam int ST_PDS = 0;
  localparam int ST_LOCK = 1;
  localparam int ST_GSUM = 2;
  // Reset values
  localparam logic [7:0] ISR_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hFF;
  localparam logic [7:0] CTRL_RST = 8'h04;
  localparam logic [7:0] THR_RST = 8'h04;
  localparam logic [7:0] XS_RST = 8'hFF;
  // Bus answers
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MF_PERIOD_NS = 2000000;
  localparam int MF_CYCLES = MF_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ---- testbench/hfe_status_events_tb.sv ----
`timescale 1ns/1ps
module hfe_status_events_tb;
  typedef struct {logic [31:0] d; logic [1:0] r; logic [31:0] m; string n;} hfe_exp_t;
  // Bus side, driven at time zero
  logic clock_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid, pds, rx_store, fso, tx_abort, tx_dis, irq;
  logic [1:0] bresp, rresp;
  // Line side: pulses by index, levels by name
  logic [5:0] lp = 6'h00;
  logic prbs = 1'h0, rx_full = 1'h0, tx_act = 1'h0, tx_empty = 1'h0, tx_me = 1'h0;
  logic [7:0] su_cnt = 8'h00;
  logic [127:0] sig_shift;
  logic [7:0] xs [16];
  hfe_exp_t notes[$];
  logic [1:0] bnotes[$];
  int num_errors = 0;
  int checks = 0;
  int cyc = 0;

  always #5 clock_i = ~clock_i;

  // Short multiframe so ticks come every 20 cycles
  hfe_status_events #(.MF_CYCLES(20), .CNT_W(8)) DUT (
    .clock_i(clock_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .prbs_sync_i(prbs), .pattern_detect_status_o(pds),
    .rx_byte_valid_i(lp[0]), .rx_fifo_full_i(rx_full), .rx_frame_end_i(lp[1]),
    .rx_store_o(rx_store), .frame_status_overflow_o(fso),
    .tx_frame_active_i(tx_act), .tx_byte_req_i(lp[2]), .tx_fifo_empty_i(tx_empty),
    .tx_message_end_cmd_i(tx_me), .tx_last_bit_i(lp[3]), .tx_abort_o(tx_abort),
    .tx_disable_o(tx_dis), .tx_sig_shift_o(sig_shift),
    .su_err_count_i(su_cnt), .su_invalid_frame_i(lp[4]), .su_valid_frame_i(lp[5]),
    .irq_o(irq)
  );

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Write: both channels offered together, held until taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bnotes.push_back(r);
    @(posedge clock_i);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do @(posedge clock_i); while (!(awready && wready));
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clock_i); while (!bvalid);
    bready <= 1'h0;
  endtask

  // Read: expectation noted, compared by the monitor below
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input string n,
                    input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0);
    notes.push_back('{d, r, m, n});
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clock_i); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clock_i); while (!rvalid);
    rready <= 1'h0;
  endtask

  task automatic pulse(input int i);
    @(posedge clock_i);
    lp[i] <= 1'h1;
    @(posedge clock_i);
    lp[i] <= 1'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock_i);
  endtask

  // Read-data monitor takes the oldest note at each accepted beat
  always @(posedge clock_i) begin
    hfe_exp_t e;
    logic [1:0] br;
    // Write answers take the oldest noted response
    if (bvalid && bready) begin
      if (bnotes.size() == 0) begin
        chk("bnote", 32'h1, 32'h0);
      end else begin
        br = bnotes.pop_front();
        chk("bresp", {30'h0, br}, {30'h0, bresp});
      end
    end
    if (rvalid && rready) begin
      if (notes.size() == 0) begin
        chk("note", 32'h1, 32'h0);
      end else begin
        e = notes.pop_front();
        chk(e.n, e.d & e.m, rdata & e.m);
        chk("rresp", {30'h0, e.r}, {30'h0, rresp});
      end
    end
  end

  // Hang guard, over ten times the expected run length
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 4000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    void'($urandom(32'h675B));
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'h1;
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr reset");
    rd(hfe_pkg::MASK_OFS, 32'hFF, "mask reset");
    rd(hfe_pkg::CTRL_OFS, 32'h04, "ctrl reset");
    rd(hfe_pkg::THR_OFS, 32'h04, "thr reset");
    rd(hfe_pkg::XS_BASE, 32'hFF, "sig reset");
    rd(8'h20, 32'h0, "unmapped", 32'hFFFFFFFF, 2'h2);
    wr(8'h20, 32'h0, 2'h2);
    // Multiframe flag masked so it stays out of the way; underrun left unmasked
    wr(hfe_pkg::MASK_OFS, 32'h08, 2'h0);
    wr(hfe_pkg::CTRL_OFS, 32'h0E, 2'h0);
    @(posedge clock_i) prbs <= 1'h1;
    idle(2);
    chk("irq", 32'h1, {31'h0, irq});
    chk("pds", 32'h1, {31'h0, pds});
    rd(hfe_pkg::STAT_OFS, 32'h05, "status");
    rd(hfe_pkg::ISR_OFS, 32'h80, "isr pat");
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr clr");
    // Event lands on the same edge as the clearing read
    fork
      rd(hfe_pkg::ISR_OFS, 32'h00, "isr race");
      begin @(posedge clock_i) prbs <= 1'h0; end
    join
    rd(hfe_pkg::ISR_OFS, 32'h80, "isr kept");
    @(posedge clock_i) rx_full <= 1'h1;
    lp[0] <= 1'h1;
    @(posedge clock_i) chk("store", 32'h0, {31'h0, rx_store});
    lp[0] <= 1'h0;
    rx_full <= 1'h0;
    @(posedge clock_i) chk("fso", 32'h1, {31'h0, fso});
    lp[0] <= 1'h1;
    @(posedge clock_i) chk("store", 32'h1, {31'h0, rx_store});
    lp[0] <= 1'h0;
    rd(hfe_pkg::ISR_OFS, 32'h40, "isr ovf");
    tx_empty <= 1'h1;
    pulse(3);
    rd(hfe_pkg::ISR_OFS, 32'h20, "isr all_sent_flag");
    tx_act <= 1'h1;
    tx_me <= 1'h1;
    pulse(2);
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr no udr");
    tx_me <= 1'h0;
    pulse(2);
    // Abort and lock-out are registered, so look one edge later
    @(posedge clock_i) chk("abort", 32'h1, {31'h0, tx_abort});
    chk("disable", 32'h1, {31'h0, tx_dis});
    pulse(2);
    rd(hfe_pkg::STAT_OFS, 32'h06, "status lock");
    rd(hfe_pkg::ISR_OFS, 32'h10, "isr udr");
    chk("disable", 32'h0, {31'h0, tx_dis});
    tx_act <= 1'h0;
    // Show-masked: flag visible, interrupt line quiet
    wr(hfe_pkg::MASK_OFS, 32'h88, 2'h0);
    wr(hfe_pkg::CTRL_OFS, 32'h0F, 2'h0);
    @(posedge clock_i) prbs <= 1'h1;
    idle(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd(hfe_pkg::STAT_OFS, 32'h01, "status vis");
    // Masked multiframe tick lands too while show-masked is on
    rd(hfe_pkg::ISR_OFS, 32'h88, "isr vis");
    wr(hfe_pkg::MASK_OFS, 32'h08, 2'h0);
    wr(hfe_pkg::CTRL_OFS, 32'h0E, 2'h0);
    // Threshold boundary: equal is quiet, one above fires
    su_cnt <= 8'h04;
    idle(2);
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr su eq");
    su_cnt <= 8'h05;
    idle(2);
    rd(hfe_pkg::ISR_OFS, 32'h04, "isr su");
    pulse(4);
    idle(25);
    rd(hfe_pkg::ISR_OFS, 32'h04, "isr su rep");
    pulse(5);
    rd(hfe_pkg::ISR_OFS, 32'h00, "drain");
    idle(25);
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr su stop");
    su_cnt <= 8'h00;
    wr(hfe_pkg::CTRL_OFS, 32'h06, 2'h0);
    su_cnt <= 8'h05;
    idle(2);
    rd(hfe_pkg::ISR_OFS, 32'h00, "isr no ss7");
    su_cnt <= 8'h00;
    for (int k = 0; k < 16; k++) begin
      xs[k] = 8'($urandom);
      wr(hfe_pkg::XS_BASE + 8'(4 * k), {24'h0, xs[k]}, 2'h0);
    end
    wr(hfe_pkg::MASK_OFS, 32'h00, 2'h0);
    // Second pass without reload must resend the same content
    for (int p = 0; p < 2; p++) begin
      idle(25);
      rd(hfe_pkg::ISR_OFS, 32'h08, "isr xmb");
      for (int k = 0; k < 16; k++) chk("shift", {24'h0, xs[k]}, {24'h0, sig_shift[8*k +: 8]});
    end
    // Frame end drops the per-frame overflow mark
    pulse(1);
    @(posedge clock_i) chk("fso end", 32'h0, {31'h0, fso});
    complete_run();
  end
endmodule
